// ==== hdl/serdes_defines.svh ====
// Offsets, field positions, reset values and timing counts of the link block.
// Assumes a 100 MHz system clock; included by every hdl module file.
`ifndef SERDES_DEFINES_SVH
`define SERDES_DEFINES_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define OFF_CTRL      8'h00
`define OFF_STATUS    8'h04
`define OFF_IRQ_ST    8'h08
`define OFF_IRQ_MASK  8'h0c
`define OFF_RXDATA    8'h10
`define CTRL_SER_EN   0
`define CTRL_DES_EN   1
`define CTRL_RESET    2'h3
`define IRQ_SER_LOCK  0
`define IRQ_DES_LOCK  1
`define IRQ_DES_LOST  2
`define IRQ_TIMEOUT   3

// ****************************************************************
// Framing and timing
// ****************************************************************
`define SYNC_WORD        10'h3e0
`define FRAME_LAST       4'hb
`define RCLK_HIGH_BITS   4'h6
`define TX_LOCK_PERIODS  12'h800
`define TRANSMIT_CLOCK_STALL_CYC   7'h7f
`define LOCK_FRAMES_LAST 3'h3
`define LOSS_FRAMES_LAST 3'h3
`define CLK_PERIOD_NS    10
`define LOCK_WAKE_NS     15000
`define LOCK_PATTERN_NS  7000
`define LOCK_WAKE_CYC    11'(`LOCK_WAKE_NS / `CLK_PERIOD_NS)
`define LOCK_PATTERN_CYC 11'(`LOCK_PATTERN_NS / `CLK_PERIOD_NS)

`endif

// ==== hdl/serdes_pkg.sv ====
// Types shared by the link block files.
// Assumes nothing of its surroundings.
package serdes_pkg;
   // Receiver alignment states
   typedef enum logic [1:0] {
      DES_DOWN,
      DES_HUNT,
      DES_ALIGN,
      DES_LOCKED
   } des_state_t;
   // One parallel data word
   typedef logic [9:0] word_t;
endpackage : serdes_pkg

// ==== hdl/frame_serializer.sv ====
// Frame builder and shifter of the transmit half, one bit per clock.
// Assumes run is low until the transmit loop has locked.
`timescale 1ns/1ns
`default_nettype none
`include "serdes_defines.svh"
module frame_serializer (
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              run,
   input  wire logic              send_sync,
   input  wire serdes_pkg::word_t word,
   output var  logic              serial_bit
);
   import serdes_pkg::*;

   logic [11:0] sh_q;
   logic [3:0]  cnt_q;

   // ****************************************************************
   // Framing
   // ****************************************************************
   wire         load = (cnt_q == `FRAME_LAST);
   // [RL9] sync pattern on request
   wire word_t  payload = send_sync ? `SYNC_WORD : word;
   // [RL13] embedded clock bits
   wire [11:0]  frame = {1'b1, payload, 1'b0};

   // Shifter, most significant bit first
   always_ff @(posedge clk) begin
      if (sys_rst || !run) begin
         sh_q  <= 12'h000;
         cnt_q <= `FRAME_LAST;
      end else if (load) begin
         sh_q  <= frame;
         cnt_q <= 4'h0;
      end else begin
         sh_q  <= {sh_q[10:0], 1'b0};
         cnt_q <= cnt_q + 4'h1;
      end
   end

   assign serial_bit = sh_q[11];
endmodule : frame_serializer
`default_nettype wire

// ==== hdl/lock_deserializer.sv ====
// Receive half: frame alignment, lock detection and word extraction.
// Assumes line_bit and line_ok are already synchronised to clk.
`timescale 1ns/1ns
`default_nettype none
`include "serdes_defines.svh"
module lock_deserializer (
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   input  wire logic                   powered,
   input  wire logic                   line_bit,
   input  wire logic                   line_ok,
   output var  serdes_pkg::des_state_t state_q,
   output var  logic [3:0]             bit_cnt_q,
   output var  serdes_pkg::word_t      rx_word_q,
   output var  logic                   word_stb_q,
   output var  logic                   lock_gain_q,
   output var  logic                   lock_lost_q,
   output var  logic                   timeout_q
);
   import serdes_pkg::*;

   des_state_t  state_d;
   logic [11:0] sh_q;
   logic [2:0]  good_q;
   logic [2:0]  bad_q;
   logic        frame_bad_q;
   logic        wake_q;
   logic [10:0] tmr_q;

   // ****************************************************************
   // Frame decode
   // ****************************************************************
   wire [11:0] sh_d      = {sh_q[10:0], line_bit};
   wire        frame_end = (bit_cnt_q == `FRAME_LAST);
   wire        is_sync   = line_ok && (sh_d == {1'b1, `SYNC_WORD, 1'b0});
   wire        clock_ok  = line_ok && !frame_bad_q && sh_d[11] && !sh_d[0];
   wire        good_word = (state_q == DES_LOCKED) && frame_end && clock_ok;
   wire [10:0] limit     = wake_q ? `LOCK_WAKE_CYC : `LOCK_PATTERN_CYC;
   wire        counting  = line_ok && (state_q == DES_HUNT || state_q == DES_ALIGN);

   // Next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         DES_DOWN: state_d = DES_HUNT;
         DES_HUNT: if (is_sync) state_d = DES_ALIGN;
         DES_ALIGN: begin
            if (frame_end && !is_sync) state_d = DES_HUNT;
            else if (frame_end && good_q == `LOCK_FRAMES_LAST) state_d = DES_LOCKED;
         end
         DES_LOCKED: begin
            // [RL11] four bad frames drop lock
            if (frame_end && !clock_ok && bad_q == `LOSS_FRAMES_LAST) state_d = DES_HUNT;
         end
         default: state_d = DES_DOWN;
      endcase
      if (!powered) state_d = DES_DOWN;
   end

   // Alignment and counters
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q     <= DES_DOWN;
         sh_q        <= 12'h000;
         bit_cnt_q   <= 4'h0;
         good_q      <= 3'h0;
         bad_q       <= 3'h0;
         frame_bad_q <= 1'b0;
      end else begin
         state_q     <= state_d;
         sh_q        <= sh_d;
         bit_cnt_q   <= (state_q == DES_HUNT || frame_end) ? 4'h0 : bit_cnt_q + 4'h1;
         good_q      <= (state_q == DES_HUNT) ? 3'h1 : good_q + {2'h0, frame_end};
         // [RL3] invalid line counts as a bad frame
         frame_bad_q <= !frame_end && (frame_bad_q || !line_ok);
         bad_q       <= (state_q != DES_LOCKED || good_word) ? 3'h0
                        : bad_q + {2'h0, frame_end};
      end
   end

   // Word output and lock events
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rx_word_q   <= 10'h000;
         word_stb_q  <= 1'b0;
         lock_gain_q <= 1'b0;
         lock_lost_q <= 1'b0;
      end else begin
         // [RL14] words only while locked
         word_stb_q  <= good_word;
         if (good_word) rx_word_q <= sh_d[10:1];
         lock_gain_q <= (state_q != DES_LOCKED) && (state_d == DES_LOCKED);
         lock_lost_q <= (state_q == DES_LOCKED) && (state_d != DES_LOCKED);
      end
   end

   // [RL4] [RL5] lock deadline watch
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wake_q    <= 1'b0;
         tmr_q     <= 11'h000;
         timeout_q <= 1'b0;
      end else begin
         wake_q    <= (state_q == DES_DOWN) || (wake_q && line_ok && state_q != DES_LOCKED);
         tmr_q     <= !counting ? 11'h000 : (tmr_q == limit) ? tmr_q : tmr_q + 11'h001;
         timeout_q <= counting && (tmr_q == limit - 11'h001);
      end
   end
endmodule : lock_deserializer
`default_nettype wire

// ==== hdl/serdes_link_lock_timing.sv ====
// Serializer and deserializer lock logic with an AHB-Lite register slave.
// Assumes all link pins are asynchronous to clk; one bit of the serial
// line lasts one clk cycle; clk also acts as the receiver reference clock.
// Function
// [RL1] Source keeps transmit clock duty 40 to 60 percent
// [RL2] Transmit loop locks after 2048 clock periods
// [RL3] Tri-stated line drops lock, needs resynchronisation
// [RL4] Lock from wake within stated deadline
// [RL5] Lock from arriving patterns within stated deadline
// [RL6] Send sync patterns before receiver wakes
// [RL7] Reference clock stable before relying on timing
// [RL8] Initialise by wake or pattern arrival path
// [RL9] Either sync request sends sync patterns
// [RL10] Active low lock output high when unlocked
// [RL11] Lock lost after four bad frames
// [RL12] Parallel outputs undriven until locked
// [RL13] Each word framed by one and zero
// [RL14] No valid data unlocked, clock matches frames
`timescale 1ns/1ns
`default_nettype none
`include "serdes_defines.svh"
module serdes_link_lock_timing (
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // AHB-Lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output var  logic [31:0]       hrdata,
   output var  logic              hreadyout,
   output var  logic              hresp,
   // Transmit side pins
   input  wire logic              transmit_clock,
   input  wire serdes_pkg::word_t tx_data,
   input  wire logic              sync_request_a,
   input  wire logic              sync_request_b,
   input  wire logic              power_down_n,
   output var  logic              serial_out_pos,
   output var  logic              serial_out_neg,
   output var  logic              serial_out_oe,
   // Receive side pins
   input  wire logic              serial_input_pos,
   input  wire logic              serial_input_neg,
   output var  serdes_pkg::word_t rx_data,
   output var  logic              rx_data_oe,
   output var  logic              rx_valid,
   output var  logic              recovered_clock,
   output var  logic              lock_n,
   output var  logic              irq
);
   import serdes_pkg::*;

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [15:0] pin_s1_q;
   logic [15:0] pin_s2_q;
   logic        transmit_clock_d_q;

   wire [15:0] pins = {tx_data, transmit_clock, sync_request_a,
                       sync_request_b, power_down_n,
                       serial_input_pos, serial_input_neg};

   // Two flip-flops on every pin
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin_s1_q <= 16'h0000;
         pin_s2_q <= 16'h0000;
         transmit_clock_d_q <= 1'b0;
      end else begin
         pin_s1_q <= pins;
         pin_s2_q <= pin_s1_q;
         transmit_clock_d_q <= pin_s2_q[5];
      end
   end

   // Named views of the synchronised pins
   wire word_t tx_data_s = pin_s2_q[15:6];
   wire        transmit_clock_s    = pin_s2_q[5];
   wire        sync_req  = pin_s2_q[4] | pin_s2_q[3];
   wire        powered   = pin_s2_q[2];
   wire        line_bit  = pin_s2_q[1];
   // [RL3] equal legs mean an undriven line
   wire        line_ok   = pin_s2_q[1] ^ pin_s2_q[0];
   wire        tx_edge   = transmit_clock_s & ~transmit_clock_d_q;

   // ****************************************************************
   // Transmit loop lock
   // ****************************************************************
   logic [11:0] tx_cnt_q;
   logic [6:0]  stall_q;
   logic        ser_locked_q;
   word_t       tx_word_q;

   wire stalled  = (stall_q == `TRANSMIT_CLOCK_STALL_CYC);
   wire tx_reset = !powered || stalled;
   wire tx_full  = (tx_cnt_q == `TX_LOCK_PERIODS);
   wire ser_gain = !tx_reset && tx_edge && tx_full && !ser_locked_q;

   // [RL2] lock on edge 2049, 2048 periods on
   always_ff @(posedge clk) begin
      if (sys_rst || tx_reset) begin
         tx_cnt_q     <= 12'h000;
         stall_q      <= 7'h00;
         ser_locked_q <= 1'b0;
      end else begin
         stall_q <= tx_edge ? 7'h00 : stall_q + 7'h01;
         if (tx_edge && tx_full) ser_locked_q <= 1'b1;
         else if (tx_edge) tx_cnt_q <= tx_cnt_q + 12'h001;
      end
   end

   // Word capture on each transmit clock rise
   always_ff @(posedge clk) begin
      if (sys_rst) tx_word_q <= 10'h000;
      else if (tx_edge) tx_word_q <= tx_data_s;
   end

   // ****************************************************************
   // Serializer and deserializer
   // ****************************************************************
   logic       ser_bit;
   des_state_t des_state;
   logic [3:0] des_bit_cnt;
   word_t      des_word;
   logic       des_stb;
   logic       des_gain;
   logic       des_lost;
   logic       des_timeout;

   frame_serializer u_ser (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .run        (ser_locked_q),
      .send_sync  (sync_req),
      .word       (tx_word_q),
      .serial_bit (ser_bit)
   );

   lock_deserializer u_des (
      .clk         (clk),
      .sys_rst     (sys_rst),
      .powered     (powered),
      .line_bit    (line_bit),
      .line_ok     (line_ok),
      .state_q     (des_state),
      .bit_cnt_q   (des_bit_cnt),
      .rx_word_q   (des_word),
      .word_stb_q  (des_stb),
      .lock_gain_q (des_gain),
      .lock_lost_q (des_lost),
      .timeout_q   (des_timeout)
   );

   wire des_locked = (des_state == DES_LOCKED);

   // ****************************************************************
   // Register slave
   // ****************************************************************
   logic [1:0]  ctrl_q;
   logic [3:0]  irq_st_q;
   logic [3:0]  irq_mask_q;
   logic        wr_pend_q;
   logic [31:0] wr_addr_q;

   // Full-word match of a register offset
   function automatic logic reg_hit(input logic [31:0] a, input logic [7:0] off);
      reg_hit = (a[31:8] == 24'h000000) && (a[7:0] == off);
   endfunction : reg_hit

   // Address phase decode and read selection
   wire        ahb_take   = hsel && hready && htrans[1];
   wire        word_write = ahb_take && hwrite && (hsize == 3'h2);
   wire [31:0] status_word = {26'h0000000, powered, sync_req,
                              2'(des_state), des_locked, ser_locked_q};
   wire [31:0] rd_data =
      reg_hit(haddr, `OFF_CTRL)     ? {30'h00000000, ctrl_q} :
      reg_hit(haddr, `OFF_STATUS)   ? status_word :
      reg_hit(haddr, `OFF_IRQ_ST)   ? {28'h0000000, irq_st_q} :
      reg_hit(haddr, `OFF_IRQ_MASK) ? {28'h0000000, irq_mask_q} :
      reg_hit(haddr, `OFF_RXDATA)   ? {22'h000000, des_word} :
                                      32'h00000000;

   // Data phase write decode
   wire wr_ctrl = wr_pend_q && reg_hit(wr_addr_q, `OFF_CTRL);
   wire wr_st   = wr_pend_q && reg_hit(wr_addr_q, `OFF_IRQ_ST);
   wire wr_mask = wr_pend_q && reg_hit(wr_addr_q, `OFF_IRQ_MASK);

   // Bus handshake; a word write costs one wait state
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wr_pend_q <= 1'b0;
         wr_addr_q <= 32'h00000000;
      end else begin
         hresp     <= 1'b0;
         wr_pend_q <= word_write;
         hreadyout <= !word_write;
         if (ahb_take) wr_addr_q <= haddr;
         if (ahb_take && !hwrite) hrdata <= rd_data;
      end
   end

   // Control and mask registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_q     <= `CTRL_RESET;
         irq_mask_q <= 4'h0;
      end else begin
         if (wr_ctrl) ctrl_q <= hwdata[1:0];
         if (wr_mask) irq_mask_q <= hwdata[3:0];
      end
   end

   // ****************************************************************
   // Interrupts
   // ****************************************************************
   logic [3:0] irq_ev;

   always_comb begin
      irq_ev                = 4'h0;
      irq_ev[`IRQ_SER_LOCK] = ser_gain;
      irq_ev[`IRQ_DES_LOCK] = des_gain;
      irq_ev[`IRQ_DES_LOST] = des_lost;
      irq_ev[`IRQ_TIMEOUT]  = des_timeout;
   end

   // Write one clears, a new event wins
   wire [3:0] irq_clr  = wr_st ? hwdata[3:0] : 4'h0;
   wire [3:0] irq_st_d = (irq_st_q & ~irq_clr) | irq_ev;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_st_q <= 4'h0;
         irq      <= 1'b0;
      end else begin
         irq_st_q <= irq_st_d;
         irq      <= |(irq_st_q & irq_mask_q);
      end
   end

   // ****************************************************************
   // Pin outputs
   // ****************************************************************
   logic ser_run_q;
   // [RL3] line released when disabled or unlocked; lags lock to meet the first bit
   wire ser_drive = ser_run_q && ctrl_q[`CTRL_SER_EN];
   // [RL12] parallel outputs driven only when locked
   wire des_drive = des_locked && ctrl_q[`CTRL_DES_EN];

   // Serial line registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         serial_out_pos <= 1'b0;
         serial_out_neg <= 1'b0;
         serial_out_oe  <= 1'b0;
         ser_run_q      <= 1'b0;
      end else begin
         ser_run_q      <= ser_locked_q;
         serial_out_pos <= ser_bit & ser_drive;
         serial_out_neg <= ~ser_bit & ser_drive;
         serial_out_oe  <= ser_drive;
      end
   end

   // Parallel output registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rx_data         <= 10'h000;
         rx_data_oe      <= 1'b0;
         rx_valid        <= 1'b0;
         recovered_clock <= 1'b0;
         lock_n          <= 1'b1;
      end else begin
         rx_data         <= des_word;
         rx_data_oe      <= des_drive;
         // [RL14] valid only with lock
         rx_valid        <= des_stb && des_locked;
         // [RL14] one clock period per frame
         recovered_clock <= des_locked && (des_bit_cnt < `RCLK_HIGH_BITS);
         // [RL10] lock output low only while locked
         lock_n          <= !des_locked;
      end
   end
endmodule : serdes_link_lock_timing
`default_nettype wire

// ==== sim/link_lock_properties.sv ====
// Concurrent checks on the ports of the link block.
// Assumes one clock domain and hready tied to hreadyout.
`timescale 1ns/1ns
`default_nettype none
module link_lock_properties (
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic       hsel,
   input wire logic [1:0] htrans,
   input wire logic       hwrite,
   input wire logic [2:0] hsize,
   input wire logic       hready,
   input wire logic       hreadyout,
   input wire logic       power_down_n,
   input wire logic       serial_out_pos,
   input wire logic       serial_out_neg,
   input wire logic       serial_out_oe,
   input wire logic       rx_data_oe,
   input wire logic       rx_valid,
   input wire logic       recovered_clock,
   input wire logic       lock_n
);
   // ********
   // Port relations
   // ********
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // Bus request and one-wait write
   sequence taken_s;
      hsel && hready && htrans == 2'b10;
   endsequence
   sequence one_wait_s;
      !hreadyout ##1 hreadyout;
   endsequence
   bus_write_a: assert property (taken_s ##0 (hwrite && hsize == 3'b010) |=> one_wait_s)
      else $error("write not one wait");
   bus_read_a: assert property (taken_s ##0 !hwrite |=> hreadyout)
      else $error("read stalled");
   pwrdn_unlock_a: assert property (!power_down_n [*8] |-> lock_n)
      else $error("lock while down");
   valid_locked_a: assert property (rx_valid |-> !lock_n)
      else $error("valid unlocked");
   valid_pulse_a: assert property (rx_valid |=> !rx_valid [*8])
      else $error("valid too close");
   rxoe_unlock_a: assert property (lock_n [*8] |-> $past(rx_data_oe, 4) == 1'b0)
      else $error("outputs driven unlocked");
   rclk_unlock_a: assert property (lock_n [*8] |-> $past(recovered_clock, 4) == 1'b0)
      else $error("clock runs unlocked");
   line_pair_a: assert property (serial_out_oe |-> serial_out_neg == !serial_out_pos)
      else $error("pair not complementary");
   line_idle_a: assert property (!serial_out_oe |-> !serial_out_pos && !serial_out_neg)
      else $error("line active undriven");
   frame_edges_a: assert property ($rose(serial_out_oe) |->
      serial_out_pos ##11 (!serial_out_pos || !serial_out_oe))
      else $error("bad first frame");
endmodule : link_lock_properties
bind serdes_link_lock_timing link_lock_properties u_props (.clk, .sys_rst, .hsel, .htrans,
   .hwrite, .hsize, .hready, .hreadyout, .power_down_n, .serial_out_pos, .serial_out_neg,
   .serial_out_oe, .rx_data_oe, .rx_valid, .recovered_clock, .lock_n);
`default_nettype wire

// ==== sim/link_partner.sv ====
// Far-end serializer model driving the serial input pair of the block.
// Assumes one serial bit per clk; mode changes at a frame load.
`timescale 1ns/1ns
`default_nettype none
`include "serdes_defines.svh"
module link_partner (
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic [1:0]        mode,
   input  wire serdes_pkg::word_t word,
   output var  logic              line_pos,
   output var  logic              line_neg,
   output var  logic              frame_done,
   output var  logic              done_data,
   output var  serdes_pkg::word_t done_word
);
   import serdes_pkg::*;
   logic [11:0] frame_q;
   logic [3:0]  bit_q;
   logic [1:0]  mode_q;
   logic        flip_q;
   word_t       word_q;
   // ********
   // Frame shifter: mode 0 released, 1 sync, 2 data
   // ********
   assign frame_done = (bit_q == 4'hb);
   assign done_data  = (mode_q == 2'd2);
   assign done_word  = word_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bit_q  <= 4'hb;
         frame_q <= 12'h000;
         mode_q <= 2'd0;
         flip_q <= 1'b0;
         word_q <= 10'h000;
      end else begin
         flip_q <= ~flip_q;
         bit_q  <= frame_done ? 4'h0 : bit_q + 4'h1;
         frame_q <= frame_done ? {1'b1, (mode == 2'd1) ? `SYNC_WORD : word, 1'b0}
                               : {frame_q[10:0], 1'b0};
         if (frame_done) begin
            mode_q <= mode;
            word_q <= word;
         end
      end
   end
   // Released line: both wires toggle together
   assign line_pos = (mode_q == 2'd0) ? flip_q : frame_q[11];
   assign line_neg = (mode_q == 2'd0) ? flip_q : ~frame_q[11];
endmodule : link_partner
`default_nettype wire

// ==== sim/serdes_link_lock_timing_tb_top.sv ====
// Self-checking bench of the link block with a far-end model.
// Assumes the checker binds itself.
`timescale 1ns/1ns
`default_nettype none
`include "serdes_defines.svh"
module serdes_link_lock_timing_tb_top;
   import serdes_pkg::*;
   logic        clk = 1'b0;
   logic        sys_rst, hsel, hwrite, hreadyout, hresp, transmit_clock_run;
   logic [1:0]  htrans, far_mode;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic        transmit_clock, sync_request_a, sync_request_b, power_down_n;
   logic        serial_out_pos, serial_out_neg, serial_out_oe;
   logic        serial_input_pos, serial_input_neg, rx_data_oe, rx_valid;
   logic        recovered_clock, lock_n, irq, frame_done, done_data;
   logic [11:0] fr;
   word_t       tx_data, rx_data, far_word, done_word, w, rw;
   word_t       exp_q[$];
   int          mismatches, checks, cyc, tx_edges, n;
   // ********
   // Clocks, design and far end
   // ********
   always #5 clk = ~clk; // reference clock runs first
   // Link clock 80 ns, even duty, own phase
   initial begin
      transmit_clock = 1'b0;
      #3;
      forever #40 transmit_clock = transmit_clock_run & ~transmit_clock;
   end
   always @(posedge transmit_clock) tx_edges++;
   serdes_link_lock_timing uut (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .transmit_clock, .tx_data,
      .sync_request_a, .sync_request_b, .power_down_n, .serial_out_pos, .serial_out_neg,
      .serial_out_oe, .serial_input_pos, .serial_input_neg, .rx_data, .rx_data_oe,
      .rx_valid, .recovered_clock, .lock_n, .irq);
   link_partner far (.clk, .sys_rst, .mode(far_mode), .word(far_word),
      .line_pos(serial_input_pos), .line_neg(serial_input_neg), .frame_done, .done_data,
      .done_word);
   // ********
   // Checking helpers and reference model
   // ********
   task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check_val
   task end_of_test;
      if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         mismatches++;
         end_of_test();
      end
   end
   // Data words expected in order, else sync
   always @(posedge clk) begin
      if (frame_done && done_data) exp_q.push_back(done_word);
      if (frame_done) far_word <= 10'($urandom);
      if (rx_valid === 1'b1) begin
         rw = (exp_q.size() > 0) ? exp_q.pop_front() : `SYNC_WORD;
         check_val("rx_data", 32'(rw), 32'(rx_data));
         check_val("rx_data_oe", 32'h1, 32'(rx_data_oe));
      end
   end
   // Waits for hready; read data taken there
   task automatic wait_ready;
      logic r;
      do begin
         @(negedge clk);
         r = hreadyout;
         rd = hrdata;
         @(posedge clk);
      end while (r !== 1'b1);
   endtask : wait_ready
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      hsize <= 3'b010;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_ready();
   endtask : bus
   task automatic wait_lock(input int limit);
      n = 0;
      while (lock_n !== 1'b0 && n < limit) begin
         @(negedge clk);
         n++;
      end
   endtask : wait_lock
   // Collects one frame, driving the transmit inputs
   task automatic grab(input logic [1:0] s, input word_t wd);
      for (int i = 0; i < 12; i++) begin
         fr = {fr[10:0], serial_out_pos};
         @(posedge clk);
         {sync_request_a, sync_request_b} <= s;
         tx_data <= wd;
         @(negedge clk);
      end
   endtask : grab
   // ********
   // Main sequence
   // ********
   initial begin
      void'($urandom(47476));
      {sys_rst, hsel, hwrite, transmit_clock_run, sync_request_a, sync_request_b} = 6'b100000;
      {htrans, haddr, hwdata, hsize, tx_data, far_word} = '0;
      power_down_n = 1'b0;
      far_mode = 2'd1;
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      bus(0, 32'h00, 0);
      check_val("ctrl", 32'h3, rd);
      bus(0, 32'h0c, 0);
      check_val("irq_mask", 32'h0, rd);
      bus(1, 32'h04, 32'hffff_ffff);
      bus(0, 32'h04, 0);
      check_val("status", 32'h0, rd);
      bus(1, 32'h20, 32'hffff_ffff);
      bus(0, 32'h20, 0);
      check_val("unmapped", 32'h0, rd);
      // Wake path, sync patterns already arriving
      @(posedge clk) power_down_n <= 1'b1;
      wait_lock(1500);
      check_val("wake lock", 32'h1, 32'(n < 1500));
      bus(0, 32'h04, 0);
      check_val("status", 32'h2e, rd);
      @(posedge clk) far_mode <= 2'd2;
      repeat (120) @(posedge clk);
      far_mode <= 2'd0;
      repeat (36) @(posedge clk);
      far_mode <= 2'd2;
      repeat (60) @(negedge clk);
      check_val("lock kept", 32'h0, 32'(lock_n));
      @(posedge clk) far_mode <= 2'd0;
      repeat (80) @(negedge clk);
      check_val("lock lost", 32'h1, 32'(lock_n));
      @(posedge clk) far_mode <= 2'd1; // pattern path
      wait_lock(700);
      check_val("pattern lock", 32'h1, 32'(n < 700));
      @(posedge clk) far_mode <= 2'd2;
      repeat (120) @(posedge clk);
      // Transmit loop lock, then sync and data frames
      transmit_clock_run <= 1'b1;
      sync_request_a <= 1'b1;
      while (serial_out_oe !== 1'b1) @(negedge clk);
      check_val("tx lock edges", 32'd2049, 32'(tx_edges));
      grab(2'b10, 10'h000);
      check_val("sync frame a", 32'({1'b1, `SYNC_WORD, 1'b0}), 32'(fr));
      grab(2'b01, 10'h000);
      grab(2'b01, 10'h000);
      check_val("sync frame b", 32'({1'b1, `SYNC_WORD, 1'b0}), 32'(fr));
      w = 10'($urandom);
      repeat (3) grab(2'b00, w);
      check_val("data frame", 32'({1'b1, w, 1'b0}), 32'(fr));
      // Interrupt raise, mask and clear
      bus(0, 32'h08, 0);
      check_val("irq_status", 32'h7, rd & 32'h7);
      check_val("irq masked", 32'h0, 32'(irq));
      bus(1, 32'h0c, 32'h4);
      repeat (3) @(negedge clk);
      check_val("irq raised", 32'h1, 32'(irq));
      bus(1, 32'h08, 32'h4);
      repeat (3) @(negedge clk);
      check_val("irq cleared", 32'h0, 32'(irq));
      bus(0, 32'h08, 0);
      check_val("irq_status", 32'h3, rd & 32'h7);
      end_of_test();
   end
endmodule : serdes_link_lock_timing_tb_top
`default_nettype wire
